//--- rtl/pirqf_top.v
// Summary of operation
// - eight enable bits; 1 permits a source, bit 7 nvm down to bit 0 timer
// - flags set on their event regardless of own or global enable
// - bit 7 sets on nvm write done, stays until software writes zero
// - bit 6 sets when an analog conversion finishes
// - bit 5 sets on capture or compare match, unused in pwm mode
// - bit 4 sets whenever comparator two output changes, sticky
// - bit 3 sets whenever comparator one output changes, sticky
// - bit 2 sets on oscillator failure with switch to internal clock
// - bit 1 sets when timer two matches its period register
// - bit 0 sets when timer one count overflows
// - no source interrupts unless the peripheral group enable is set
`timescale 1ns/1ns
`default_nettype none
`include "pirqf_regs.vh"
module pirqf_top (
  // clock and reset
  input wire core_clk_i,
  input wire sys_rst_i,
  // register port
  input wire [`PIRQF_ADDR_W-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // event sources
  input wire nvm_write_done_i,
  input wire conversion_done_i,
  input wire [1:0] ccp_mode_i,
  input wire capture_event_i,
  input wire compare_match_i,
  input wire comparator_two_out_i,
  input wire comparator_one_out_i,
  input wire osc_fail_i,
  input wire period_match_i,
  input wire timer_one_overflow_i,
  // request to the core
  output reg peripheral_irq_o
);
  reg [7:0] peripheral_irq_enable_q;
  reg [7:0] peripheral_irq_flags_q;
  wire [7:0] peripheral_irq_flags_d;
  reg [7:0] core_irq_control_q;
  reg comparator_two_prev_q;
  reg comparator_one_prev_q;
  reg cmp_prev_valid_q;
  reg [7:0] event_w;
  reg ccp_event_w;
  wire [7:0] pending_w;
  wire wr_flags_w;
  wire global_irq_enable_w;
  wire peripheral_group_enable_w;
  genvar g;

  assign wr_flags_w = reg_wr_i && (reg_addr_i == `PIRQF_OFS_FLAGS);
  assign global_irq_enable_w = core_irq_control_q[`PIRQF_CTRL_GLOBAL];
  assign peripheral_group_enable_w = core_irq_control_q[`PIRQF_CTRL_PERIPH];
  assign pending_w = peripheral_irq_flags_q & peripheral_irq_enable_q;

  // per-source event pulses
  always @* begin
    ccp_event_w = 1'b0;
    case (ccp_mode_i)
      `PIRQF_MODE_CAPTURE: ccp_event_w = capture_event_i;
      `PIRQF_MODE_COMPARE: ccp_event_w = compare_match_i;
      default: ccp_event_w = 1'b0;
    endcase
    event_w = 8'h00;
    event_w[`PIRQF_BIT_NVM] = nvm_write_done_i;
    event_w[`PIRQF_BIT_CONV] = conversion_done_i;
    event_w[`PIRQF_BIT_CCP] = ccp_event_w;
    event_w[`PIRQF_BIT_CMP2] = cmp_prev_valid_q &&
      (comparator_two_out_i != comparator_two_prev_q);
    event_w[`PIRQF_BIT_CMP1] = cmp_prev_valid_q &&
      (comparator_one_out_i != comparator_one_prev_q);
    event_w[`PIRQF_BIT_OSC] = osc_fail_i;
    event_w[`PIRQF_BIT_PER] = period_match_i;
    event_w[`PIRQF_BIT_TOVF] = timer_one_overflow_i;
  end

  // sticky flags, event wins over a coinciding write
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_flag
      assign peripheral_irq_flags_d[g] = event_w[g] ? 1'b1 :
        (wr_flags_w ? reg_wdata_i[g] : peripheral_irq_flags_q[g]);
    end
  endgenerate

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      peripheral_irq_enable_q <= `PIRQF_ENABLE_RST;
      peripheral_irq_flags_q <= `PIRQF_FLAGS_RST;
      core_irq_control_q <= `PIRQF_CTRL_RST;
      comparator_two_prev_q <= 1'b0;
      comparator_one_prev_q <= 1'b0;
      cmp_prev_valid_q <= 1'b0;
      reg_rdata_o <= 8'h00;
      peripheral_irq_o <= 1'b0;
    end else begin
      peripheral_irq_flags_q <= peripheral_irq_flags_d;
      comparator_two_prev_q <= comparator_two_out_i;
      comparator_one_prev_q <= comparator_one_out_i;
      cmp_prev_valid_q <= 1'b1;
      if (reg_wr_i && (reg_addr_i == `PIRQF_OFS_ENABLE)) begin
        peripheral_irq_enable_q <= reg_wdata_i;
      end else if (reg_wr_i && (reg_addr_i == `PIRQF_OFS_CTRL)) begin
        core_irq_control_q <= reg_wdata_i & 8'hc0;
      end
      if (reg_rd_i && (reg_addr_i == `PIRQF_OFS_ENABLE)) begin
        reg_rdata_o <= peripheral_irq_enable_q;
      end else if (reg_rd_i && (reg_addr_i == `PIRQF_OFS_FLAGS)) begin
        reg_rdata_o <= peripheral_irq_flags_q;
      end else if (reg_rd_i && (reg_addr_i == `PIRQF_OFS_CTRL)) begin
        reg_rdata_o <= core_irq_control_q;
      end else if (reg_rd_i && (reg_addr_i == `PIRQF_OFS_STATUS)) begin
        reg_rdata_o <= pending_w;
      end else begin
        reg_rdata_o <= 8'h00;
      end
      peripheral_irq_o <= (|pending_w) && peripheral_group_enable_w &&
        global_irq_enable_w;
    end
  end
endmodule
`default_nettype wire

//--- rtl/pirqf_regs.vh
`ifndef PIRQF_REGS_VH
`define PIRQF_REGS_VH
`define PIRQF_ADDR_W 4
`define PIRQF_OFS_ENABLE 4'h0
`define PIRQF_OFS_FLAGS 4'h1
`define PIRQF_OFS_CTRL 4'h2
`define PIRQF_OFS_STATUS 4'h3
`define PIRQF_ENABLE_RST 8'h00
`define PIRQF_FLAGS_RST 8'h00
`define PIRQF_CTRL_RST 8'h00
`define PIRQF_BIT_NVM 7
`define PIRQF_BIT_CONV 6
`define PIRQF_BIT_CCP 5
`define PIRQF_BIT_CMP2 4
`define PIRQF_BIT_CMP1 3
`define PIRQF_BIT_OSC 2
`define PIRQF_BIT_PER 1
`define PIRQF_BIT_TOVF 0
`define PIRQF_CTRL_GLOBAL 7
`define PIRQF_CTRL_PERIPH 6
`define PIRQF_MODE_CAPTURE 2'h0
`define PIRQF_MODE_COMPARE 2'h1
`define PIRQF_MODE_PWM 2'h2
`endif

//--- dv/pirqf_src.sv
`timescale 1ns/1ns
`default_nettype none
module pirqf_src (
  input wire logic core_clk_i,
  input wire logic [2:0] sel_i,
  input wire logic go_i,
  output logic [7:0] ev_o = 8'h00,
  output logic cmp2_o = 1'b0,
  output logic cmp1_o = 1'b0
);
  always @(posedge core_clk_i) begin
    ev_o <= go_i ? 8'h01 << sel_i : 8'h00;
    if (go_i && sel_i == 3'h4) cmp2_o <= !cmp2_o;
    if (go_i && sel_i == 3'h3) cmp1_o <= !cmp1_o;
  end
endmodule
`default_nettype wire

//--- dv/pirqf_props.sv
`timescale 1ns/1ns
`default_nettype none
module pirqf_props (
  input wire logic core_clk_i, sys_rst_i, reg_rd_i, peripheral_irq_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] ccp_mode_i,
  input wire logic nvm_write_done_i, conversion_done_i, capture_event_i,
  input wire logic comparator_one_out_i, osc_fail_i, timer_one_overflow_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rf; reg_rd_i && reg_addr_i == 4'h1; endsequence
  property p_rz; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
  property p_nv; nvm_write_done_i ##1 s_rf |=> reg_rdata_o[7]; endproperty
  property p_cv; conversion_done_i ##1 s_rf |=> reg_rdata_o[6]; endproperty
  property p_cc;
    capture_event_i && ccp_mode_i == 2'h0 ##1 s_rf |=> reg_rdata_o[5];
  endproperty
  property p_c1;
    $changed(comparator_one_out_i) ##1 s_rf |=> reg_rdata_o[3];
  endproperty
  property p_os; osc_fail_i ##1 s_rf |=> reg_rdata_o[2]; endproperty
  property p_to; timer_one_overflow_i ##1 s_rf |=> reg_rdata_o[0]; endproperty
  property p_rq;
    reg_rd_i && reg_addr_i == 4'h3 ##1 peripheral_irq_o |-> reg_rdata_o != 0;
  endproperty
  a_rz: assert property (p_rz) else $error("rdata not idle");
  a_nv: assert property (p_nv) else $error("nvm flag");
  a_cv: assert property (p_cv) else $error("conv flag");
  a_cc: assert property (p_cc) else $error("ccp flag");
  a_c1: assert property (p_c1) else $error("cmp1 flag");
  a_os: assert property (p_os) else $error("osc flag");
  a_to: assert property (p_to) else $error("ovf flag");
  a_rq: assert property (p_rq) else $error("irq cause");
  cover property (s_rf);
  cover property (peripheral_irq_o);
  cover property ($changed(comparator_one_out_i));
endmodule
bind pirqf_top pirqf_props u_props (.*);
`default_nettype wire

//--- dv/tb_pirqf_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pirqf_top;
  logic clk = 0, rst = 1, w = 0, r = 0, go = 0, c1, c2, irq;
  logic [3:0] a = 0;
  logic [7:0] d = 0, q, ev;
  logic [2:0] s = 0;
  logic [1:0] m = 0;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #5 clk = !clk;
  pirqf_src src (.core_clk_i(clk), .sel_i(s), .go_i(go), .ev_o(ev),
    .cmp2_o(c2), .cmp1_o(c1));
  pirqf_top uut (.core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(a),
    .reg_wdata_i(d), .reg_wr_i(w), .reg_rd_i(r), .reg_rdata_o(q),
    .nvm_write_done_i(ev[7]), .conversion_done_i(ev[6]), .ccp_mode_i(m),
    .capture_event_i(ev[5]), .compare_match_i(ev[5]),
    .comparator_two_out_i(c2), .comparator_one_out_i(c1),
    .osc_fail_i(ev[2]), .period_match_i(ev[1]),
    .timer_one_overflow_i(ev[0]), .peripheral_irq_o(irq));
  task chk(input string n, input logic [7:0] e, input logic [7:0] v);
    cmp_count++;
    if (v !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", n, e, v);
    end
  endtask
  task wr(input logic [3:0] x, input logic [7:0] y);
    @(posedge clk) begin a <= x; d <= y; w <= 1; end
    @(posedge clk) w <= 0;
  endtask
  task rd(input logic [3:0] x, input logic [7:0] e);
    @(posedge clk) begin a <= x; r <= 1; end
    @(posedge clk) r <= 0;
    #1 chk("reg_rdata_o", e, q);
  endtask
  task fire(input logic [2:0] x);
    @(posedge clk) begin s <= x; go <= 1; end
    @(posedge clk) go <= 0;
  endtask
  task wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin n_mismatch++; wrap_up(); end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 6; i++) rd(i[3:0], 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(4'h1, 8'h00);
      fire(i[2:0]);
      rd(4'h1, 8'h01 << i);
    end
    @(posedge clk) m <= 2'h1;
    wr(4'h1, 8'h00);
    fire(3'h5);
    rd(4'h1, 8'h20);
    @(posedge clk) m <= 2'h2;
    wr(4'h1, 8'h00);
    fire(3'h5);
    rd(4'h1, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'hff);
    wr(4'h2, 8'h40);
    fire(3'h0);
    repeat (3) @(posedge clk);
    #1 chk("irq", 8'h00, {7'h0, irq});
    wr(4'h2, 8'hc0);
    rd(4'h3, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    fork
      fire(3'h1);
      begin @(posedge clk); wr(4'h1, 8'h00); end
    join
    rd(4'h1, 8'h02);
    wrap_up();
  end
endmodule
`default_nettype wire
